// ### rss_pkg.sv
// shared constants and types of the rail supervisor and sequencer
// assumes one 250 MHz clock and a synchronous active high reset
`default_nettype none
package rss_pkg;
  localparam int CLK_MHZ = 250;
  // register offsets (8-bit registers)
  localparam logic [3:0] OFF_REG_STATUS = 4'h0;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h1;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h2;
  localparam logic [3:0] OFF_CONV_CTRL_A = 4'h3;
  localparam logic [3:0] OFF_CONV_CTRL_B = 4'h4;
  localparam logic [3:0] OFF_LINEAR_CTRL = 4'h5;
  localparam logic [3:0] OFF_UVLO_THR = 4'h6;
  localparam logic [3:0] OFF_SEQ_STATE = 4'h7;
  // rail index within the four monitored outputs
  localparam int RAIL_IO = 0;
  localparam int RAIL_CORE = 1;
  localparam int RAIL_LIN_A = 2;
  localparam int RAIL_LIN_B = 3;
  // field positions
  localparam int FORCED_PWM_BIT = 7;
  localparam int LIN_A_EN_BIT = 0;
  localparam int LIN_B_EN_BIT = 1;
  localparam int ST_UVLO_BIT = 4;
  localparam int ST_OT_BIT = 5;
  localparam int ST_AC_OK_BIT = 6;
  localparam int ST_USB_OK_BIT = 7;
  // reset values
  localparam logic [7:0] RST_CONV_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CONV_CTRL_B = 8'h00;
  localparam logic [7:0] RST_LINEAR_CTRL = 8'h03;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  // threshold code for 2.75 V
  localparam logic [7:0] RST_UVLO_THR = 8'h03;
  // voltage codes loaded from the straps
  localparam logic [3:0] IO_V_3V0 = 4'h0;
  localparam logic [3:0] IO_V_3V3 = 4'h1;
  localparam logic [3:0] CORE_V_1V5 = 4'h0;
  localparam logic [3:0] CORE_V_1V8 = 4'h1;
  // timing
  localparam int UVLO_DLY_NS = 1000;
  localparam int OT_DLY_NS = 1000;
  localparam int SEQ_STEP_NS = 200;
  localparam logic [15:0] UVLO_DLY_CYC = 16'((UVLO_DLY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] OT_DLY_CYC = 16'((OT_DLY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] SEQ_STEP_CYC = 16'((SEQ_STEP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] STRAP_SETTLE_CYC = 16'h0004;
  // synchronised pin vector layout
  localparam int SYNC_W = 9;
  localparam int SY_VCC_LOW = 0;
  localparam int SY_OT = 1;
  localparam int SY_PWM_IO = 2;
  localparam int SY_PWM_CORE = 3;
  localparam int SY_SEQ = 4;
  localparam int SY_CORE_STRAP = 5;
  localparam int SY_IO_STRAP = 6;
  localparam int SY_AC_LOW = 7;
  localparam int SY_USB_LOW = 8;
  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_UP1 = 8'h02,
    ST_UP2 = 8'h04,
    ST_ON = 8'h08,
    ST_PFAIL = 8'h10,
    ST_DN1 = 8'h20,
    ST_DN2 = 8'h40,
    ST_OFF = 8'h80
  } rss_state_t;
endpackage
`default_nettype wire

// ### rss_pg_if.sv
// link between the sequencer and the power-good monitor
// assumes both ends run on the same clock
`default_nettype none
interface rss_pg_if;
  logic [3:0] en;
  logic [3:0] good;
  logic [3:0] fall;
  modport mon (input en, output good, output fall);
  modport ctl (output en, input good, input fall);
endinterface
`default_nettype wire

// ### rss_pg_mon.sv
// power-good monitor: synchronises comparator pins and keeps hysteresis flags
// assumes comparator pins are asynchronous to sys_clk
`default_nettype none
module rss_pg_mon (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] below_lo_pin,
  input wire logic [3:0] above_hi_pin,
  rss_pg_if.mon pg
);
  typedef struct packed {
    logic [3:0] lo_s1;
    logic [3:0] lo_s2;
    logic [3:0] hi_s1;
    logic [3:0] hi_s2;
    logic [3:0] good;
    logic [3:0] fall;
  } rss_mon_t;

  rss_mon_t r, n;

  always_comb begin
    n = r;
    n.lo_s1 = below_lo_pin;
    n.lo_s2 = r.lo_s1;
    n.hi_s1 = above_hi_pin;
    n.hi_s2 = r.hi_s1;
    for (int i = 0; i < 4; i++) begin
      n.fall[i] = 1'b0;
      if (!pg.en[i]) begin
        n.good[i] = 1'b1;
      end else if (r.lo_s2[i]) begin
        n.good[i] = 1'b0;
        n.fall[i] = r.good[i];
      end else if (r.hi_s2[i]) begin
        n.good[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '{default: '0, good: 4'hf};
    end else begin
      r <= n;
    end
  end

  assign pg.good = r.good;
  assign pg.fall = r.fall;
endmodule // rss_pg_mon
`default_nettype wire

// ### rss_supervisor.sv
// rail supervisor and power sequencer with register port
// assumes analog comparators, straps and fault pins are asynchronous
// Summary of operation
// - converter rail bad below 90 percent, hysteresis
// - linear rails use same thresholds, hysteresis
// - four good flags readable in status register
// - maskable interrupt on any rail drop
// - converter comparators idle while converter disabled
// - second linear comparator idle when disabled
// - power-on reset follows io rail good
// - overtemperature shuts both converters down
// - overtemperature only counted in PWM operation
// - linear regulators enabled after reset, programmable
// - lockout threshold defaults 2.75 V, writable
// - lockout: power fail, delay, ordered shutdown
// - overtemperature: same, with its own delay
// - automatic restart once fault clears
// - charger lockout flags independent of main
// - sequence pin picks first-up, last-down rail
// - core strap picks 1.5 or 1.8 V
// - io strap picks 3 or 3.3 V
// - forced PWM is bit 7 of control A
//
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none
module rss_supervisor
  import rss_pkg::*;
#(
  parameter logic [15:0] UVLO_DLY = UVLO_DLY_CYC,
  parameter logic [15:0] OT_DLY = OT_DLY_CYC,
  parameter logic [15:0] SEQ_STEP = SEQ_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] rail_below_lo,
  input wire logic [3:0] rail_above_hi,
  input wire logic vcc_below_uvlo,
  input wire logic overtemp_in,
  input wire logic io_auto_pwm,
  input wire logic core_auto_pwm,
  input wire logic sequence_order_pin,
  input wire logic core_voltage_strap,
  input wire logic io_voltage_strap,
  input wire logic ac_below_chg_uvlo,
  input wire logic usb_below_chg_uvlo,
  output logic io_conv_en,
  output logic core_conv_en,
  output logic linear_reg_a_en,
  output logic linear_reg_b_en,
  output logic [3:0] io_vsel,
  output logic [3:0] core_vsel,
  output logic [1:0] linear_reg_a_sel,
  output logic [1:0] linear_reg_b_sel,
  output logic forced_pwm,
  output logic [2:0] uvlo_thr_code,
  output logic power_on_reset_out_n,
  output logic power_fail_out_n,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rss_state_t st;
    logic [15:0] cnt;
    logic ot_cause;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [7:0] conv_a;
    logic [7:0] conv_b;
    logic [7:0] lin_ctl;
    logic [7:0] uvlo_thr;
    logic [7:0] irq_sts;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic io_en;
    logic core_en;
    logic io_en_d;
    logic rails_up;
    logic lin_a_on;
    logic lin_b_on;
    logic irq;
    logic por_n;
    logic pfail_n;
  } rss_regs_t;

  localparam rss_regs_t RST_REGS = '{
    st: ST_INIT,
    cnt: 16'h0000,
    ot_cause: 1'b0,
    s1: '0,
    s2: '0,
    conv_a: RST_CONV_CTRL_A,
    conv_b: RST_CONV_CTRL_B,
    lin_ctl: RST_LINEAR_CTRL,
    uvlo_thr: RST_UVLO_THR,
    irq_sts: 8'h00,
    irq_mask: RST_IRQ_MASK,
    rdata: 8'h00,
    io_en: 1'b0,
    core_en: 1'b0,
    io_en_d: 1'b0,
    rails_up: 1'b0,
    lin_a_on: 1'b0,
    lin_b_on: 1'b0,
    irq: 1'b0,
    por_n: 1'b0,
    pfail_n: 1'b0
  };

  rss_regs_t r, n;
  rss_pg_if pg ();

  // address match, shared by the write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // power-good monitor

  // rail a comparator only watches while rails are regulating
  // comparator follows regulator enable
  assign pg.en = {r.lin_b_on, r.lin_a_on, r.core_en, r.io_en};

  rss_pg_mon u_mon (
    .sys_clk(sys_clk),
    .rst(rst),
    .below_lo_pin(rail_below_lo),
    .above_hi_pin(rail_above_hi),
    .pg(pg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic pwm_on;
  logic ot_q;
  logic fault;
  logic seq_io_first;
  logic [7:0] status_word;
  logic [7:0] irq_clr;

  always_comb begin
    n = r;
    n.s1 = {usb_below_chg_uvlo, ac_below_chg_uvlo, io_voltage_strap, core_voltage_strap,
            sequence_order_pin, core_auto_pwm, io_auto_pwm, overtemp_in, vcc_below_uvlo};
    n.s2 = r.s1;
    n.rdata = 8'h00;

    pwm_on = r.conv_a[FORCED_PWM_BIT] | r.s2[SY_PWM_IO] | r.s2[SY_PWM_CORE];
    ot_q = r.s2[SY_OT] & pwm_on;
    fault = r.s2[SY_VCC_LOW] | ot_q;
    // pin low brings core up first
    seq_io_first = r.s2[SY_SEQ];

    status_word = {~r.s2[SY_USB_LOW], ~r.s2[SY_AC_LOW], ot_q, r.s2[SY_VCC_LOW], pg.good};

    // register writes
    irq_clr = 8'h00;
    if (reg_wr) begin
      if (hit(reg_addr, OFF_IRQ_STATUS)) begin
        irq_clr = reg_wdata;
      end
      if (hit(reg_addr, OFF_IRQ_MASK)) begin
        n.irq_mask = {4'h0, reg_wdata[3:0]};
      end
      if (hit(reg_addr, OFF_CONV_CTRL_A)) begin
        n.conv_a = reg_wdata;
      end
      if (hit(reg_addr, OFF_CONV_CTRL_B)) begin
        n.conv_b = reg_wdata;
      end
      if (hit(reg_addr, OFF_LINEAR_CTRL)) begin
        n.lin_ctl = reg_wdata;
      end
      if (hit(reg_addr, OFF_UVLO_THR)) begin
        n.uvlo_thr = {5'h00, reg_wdata[2:0]};
      end
    end

    // sticky drop flags, set beats clear
    n.irq_sts = (r.irq_sts & ~irq_clr) | {4'h0, pg.fall};
    n.irq = |(n.irq_sts & n.irq_mask);

    // register reads, data in the following cycle
    if (reg_rd) begin
      if (hit(reg_addr, OFF_REG_STATUS)) begin
        n.rdata = status_word;
      end else if (hit(reg_addr, OFF_IRQ_STATUS)) begin
        n.rdata = r.irq_sts;
      end else if (hit(reg_addr, OFF_IRQ_MASK)) begin
        n.rdata = r.irq_mask;
      end else if (hit(reg_addr, OFF_CONV_CTRL_A)) begin
        n.rdata = r.conv_a;
      end else if (hit(reg_addr, OFF_CONV_CTRL_B)) begin
        n.rdata = r.conv_b;
      end else if (hit(reg_addr, OFF_LINEAR_CTRL)) begin
        n.rdata = r.lin_ctl;
      end else if (hit(reg_addr, OFF_UVLO_THR)) begin
        n.rdata = r.uvlo_thr;
      end else if (hit(reg_addr, OFF_SEQ_STATE)) begin
        n.rdata = r.st;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // sequencer

    if (r.cnt != 16'h0000) begin
      n.cnt = r.cnt - 16'h0001;
    end

    case (r.st)
      ST_INIT: begin
        // wait for strap synchronisers to settle before sampling
        if (r.cnt == 16'h0000) begin
          n.cnt = STRAP_SETTLE_CYC;
        end
        if (r.cnt == 16'h0001) begin
          n.conv_a[3:0] = r.s2[SY_IO_STRAP] ? IO_V_3V3 : IO_V_3V0;
          n.conv_b[3:0] = r.s2[SY_CORE_STRAP] ? CORE_V_1V8 : CORE_V_1V5;
          n.cnt = SEQ_STEP;
          n.st = fault ? ST_OFF : ST_UP1;
        end
      end
      ST_UP1: begin
        if (seq_io_first) begin
          n.io_en = 1'b1;
        end else begin
          n.core_en = 1'b1;
        end
        if (r.cnt == 16'h0000) begin
          n.cnt = SEQ_STEP;
          n.st = ST_UP2;
        end
      end
      ST_UP2: begin
        n.io_en = 1'b1;
        n.core_en = 1'b1;
        if (r.cnt == 16'h0000) begin
          n.st = ST_ON;
        end
      end
      ST_ON: begin
        n.rails_up = 1'b1;
      end
      ST_PFAIL: begin
        // outputs stay up while power fail warns the processor
        if (r.cnt == 16'h0000) begin
          n.cnt = SEQ_STEP;
          n.st = ST_DN1;
        end
      end
      ST_DN1: begin
        // linear rails and last-up rail go first
        n.rails_up = 1'b0;
        if (seq_io_first) begin
          n.core_en = 1'b0;
        end else begin
          n.io_en = 1'b0;
        end
        if (r.cnt == 16'h0000) begin
          n.cnt = SEQ_STEP;
          n.st = ST_DN2;
        end
      end
      ST_DN2: begin
        n.io_en = 1'b0;
        n.core_en = 1'b0;
        if (r.cnt == 16'h0000) begin
          n.st = ST_OFF;
        end
      end
      ST_OFF: begin
        if (!fault) begin
          n.cnt = SEQ_STEP;
          n.st = ST_UP1;
        end
      end
      default: begin
        n.st = ST_INIT;
        n.cnt = 16'h0000;
      end
    endcase

    // a fault while rising or running starts the shutdown
    if (fault && (r.st == ST_UP1 || r.st == ST_UP2 || r.st == ST_ON)) begin
      n.st = ST_PFAIL;
      n.ot_cause = ~r.s2[SY_VCC_LOW];
      n.cnt = r.s2[SY_VCC_LOW] ? UVLO_DLY : OT_DLY;
    end

    // enabled by default once rails are up
    n.lin_a_on = n.rails_up & n.lin_ctl[LIN_A_EN_BIT];
    n.lin_b_on = n.rails_up & n.lin_ctl[LIN_B_EN_BIT];

    // reset released only with io rail good
    // first enabled cycle still shows the idle-forced good flag
    n.io_en_d = r.io_en;
    n.por_n = r.io_en_d & r.io_en & pg.good[RAIL_IO];
    // power fail low first, held with reset
    n.pfail_n = n.por_n & ~fault & ~(n.st == ST_PFAIL || n.st == ST_DN1 ||
                                     n.st == ST_DN2 || n.st == ST_OFF);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= RST_REGS;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign reg_rdata = r.rdata;
  assign io_conv_en = r.io_en;
  assign core_conv_en = r.core_en;
  assign linear_reg_a_en = r.lin_a_on;
  assign linear_reg_b_en = r.lin_b_on;
  assign io_vsel = r.conv_a[3:0];
  assign core_vsel = r.conv_b[3:0];
  assign linear_reg_a_sel = r.lin_ctl[5:4];
  assign linear_reg_b_sel = r.lin_ctl[7:6];
  assign forced_pwm = r.conv_a[FORCED_PWM_BIT];
  // threshold code to the lockout comparator
  assign uvlo_thr_code = r.uvlo_thr[2:0];
  assign power_on_reset_out_n = r.por_n;
  assign power_fail_out_n = r.pfail_n;
  assign irq_out = r.irq;

endmodule // rss_supervisor
`default_nettype wire

// ### rss_supervisor_properties.sv
// port checker of the supervisor: register port, reset output and shutdown
// assumes it is bound to every rss_supervisor instance
`default_nettype none
module rss_supervisor_properties
  import rss_pkg::*;
#(
  parameter logic [15:0] UVLO_DLY = UVLO_DLY_CYC,
  parameter logic [15:0] OT_DLY = OT_DLY_CYC,
  parameter logic [15:0] SEQ_STEP = SEQ_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic io_conv_en,
  input wire logic core_conv_en,
  input wire logic linear_reg_a_en,
  input wire logic forced_pwm,
  input wire logic [2:0] uvlo_thr_code,
  input wire logic power_on_reset_out_n,
  input wire logic power_fail_out_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_lin_off_write: assert property (reg_wr && reg_addr == OFF_LINEAR_CTRL
    && !reg_wdata[LIN_A_EN_BIT] |=> !linear_reg_a_en)
    else $error("linear enable stayed on after clear");
  a_forced_pwm_bit_follows: assert property (reg_wr && reg_addr == OFF_CONV_CTRL_A
    |=> forced_pwm == $past(reg_wdata[FORCED_PWM_BIT]))
    else $error("forced pwm differs from written bit");
  a_thr_follows: assert property (reg_wr && reg_addr == OFF_UVLO_THR
    |=> uvlo_thr_code == $past(reg_wdata[2:0]))
    else $error("lockout code differs from written value");
  a_por_needs_io: assert property (!$past(io_conv_en) |-> !power_on_reset_out_n)
    else $error("reset released with io converter off");
  a_por_waits_rail: assert property ($rose(io_conv_en) |=> !power_on_reset_out_n)
    else $error("reset released in the first cycle of the io converter");
  a_fail_before_off: assert property ($fell(io_conv_en) || $fell(core_conv_en)
    |-> !power_fail_out_n)
    else $error("converter dropped without power fail");
  a_fail_holds_rails: assert property ($fell(power_fail_out_n) && power_on_reset_out_n
    |=> $stable({io_conv_en, core_conv_en}) [*2])
    else $error("converters changed inside the fault delay");
endmodule // rss_supervisor_properties
bind rss_supervisor rss_supervisor_properties #(
  .UVLO_DLY(UVLO_DLY), .OT_DLY(OT_DLY), .SEQ_STEP(SEQ_STEP)
) u_props (
  .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_conv_en,
  .core_conv_en, .linear_reg_a_en, .forced_pwm, .uvlo_thr_code, .power_on_reset_out_n,
  .power_fail_out_n
);
`default_nettype wire

// ### rss_rail_model.sv
// behavioural rail comparators standing in for the analog outputs
// assumes one enable and one droop request per rail
`default_nettype none
module rss_rail_model #(
  parameter logic [3:0] RISE = 4'h3
) (
  input wire logic sys_clk,
  input wire logic [3:0] en,
  input wire logic [3:0] droop,
  output logic [3:0] below_lo,
  output logic [3:0] above_hi
);
  logic [3:0][3:0] age_r = '0;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      // a disabled rail collapses, so it reads as undervoltage
      if (!en[i] || droop[i])
        age_r[i] <= 4'h0;
      else if (age_r[i] != RISE)
        age_r[i] <= age_r[i] + 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      below_lo[i] = age_r[i] < 4'h2;
      above_hi[i] = age_r[i] == RISE;
    end
  end
endmodule // rss_rail_model
`default_nettype wire

// ### rail_supervisor_sequencer_test.sv
// self-checking bench of the rail supervisor and sequencer
// assumes the rail model stands for the analog comparators
`default_nettype none
module rail_supervisor_sequencer_test
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] droop = 4'h0;
  logic vcc_low = 1'b0;
  logic ot = 1'b0;
  logic core_ap = 1'b0;
  logic io_ap = 1'b0;
  logic seq = 1'b0;
  logic cstrap = 1'b0;
  logic iostrap = 1'b0;
  logic ac_low = 1'b0;
  logic usb_low = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] below;
  logic [3:0] above;
  logic io_en, core_en, la_en, lb_en, forced_pwm_bit, por_n, pf_n, irq;
  logic [2:0] thr;
  logic [2:0] thr_w;
  logic [3:0] lsel_w;
  logic [3:0] io_v, core_v;
  logic [1:0] la_sel, lb_sel;
  logic [7:0] io_ctl;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2 sys_clk = ~sys_clk;
  assign io_ctl = {4'h0, iostrap ? IO_V_3V3 : IO_V_3V0};

  rss_supervisor #(.UVLO_DLY(16'h0004), .OT_DLY(16'h0006), .SEQ_STEP(16'h0004)) u_rss_supervisor (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rail_below_lo(below),
    .rail_above_hi(above), .vcc_below_uvlo(vcc_low), .overtemp_in(ot), .io_auto_pwm(io_ap),
    .core_auto_pwm(core_ap), .sequence_order_pin(seq), .core_voltage_strap(cstrap),
    .io_voltage_strap(iostrap), .ac_below_chg_uvlo(ac_low), .usb_below_chg_uvlo(usb_low),
    .io_conv_en(io_en), .core_conv_en(core_en), .linear_reg_a_en(la_en),
    .linear_reg_b_en(lb_en), .io_vsel(io_v), .core_vsel(core_v), .linear_reg_a_sel(la_sel),
    .linear_reg_b_sel(lb_sel), .forced_pwm(forced_pwm_bit), .uvlo_thr_code(thr),
    .power_on_reset_out_n(por_n), .power_fail_out_n(pf_n), .irq_out(irq)
  );
  rss_rail_model u_rss_rail_model (
    .sys_clk(sys_clk), .en({lb_en, la_en, core_en, io_en}), .droop(droop),
    .below_lo(below), .above_hi(above)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, seen, want);
    end
  endtask
  // gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic logic st(input int s);
    case (s)
      0: return io_en | core_en;
      1: return !(io_en && core_en);
      2: return !pf_n;
      3: return la_en;
      default: return !(io_en || core_en);
    endcase
  endfunction
  task automatic till(input int s);
    for (int i = 0; i < 400 && !st(s); i++)
      @(posedge sys_clk);
    chk(st(s), 1'b1);
  endtask
  task automatic order();
    chk({6'h0, io_en, core_en}, seq ? 8'h02 : 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    rd_q <= reg_rd;
    if (rd_q)
      chk(reg_rdata, exp_q.pop_front());
  end
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h2c17));
    {seq, cstrap, iostrap, ac_low, usb_low} <= 5'($urandom);
    thr_w = 3'($urandom);
    lsel_w = 4'($urandom);
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    till(0);
    order();
    rd(OFF_CONV_CTRL_A, io_ctl);
    rd(OFF_CONV_CTRL_B, {4'h0, cstrap ? CORE_V_1V8 : CORE_V_1V5});
    rd(OFF_LINEAR_CTRL, RST_LINEAR_CTRL);
    rd(OFF_UVLO_THR, RST_UVLO_THR);
    rd(4'h8 | 4'($urandom), 8'h00);
    chk(io_v, io_ctl);
    chk(core_v, cstrap ? CORE_V_1V8 : CORE_V_1V5);
    till(3);
    repeat (10) @(posedge sys_clk);
    rd(OFF_REG_STATUS, {~usb_low, ~ac_low, 6'h0f});
    chk(por_n, 1'b1);
    wr(OFF_UVLO_THR, {5'h00, thr_w});
    chk(thr, thr_w);
    rd(OFF_UVLO_THR, {5'h00, thr_w});
    // rails rising from idle leave drop flags behind
    wr(OFF_IRQ_STATUS, 8'h0f);
    wr(OFF_IRQ_MASK, 8'h08);
    droop <= 4'h4;
    repeat (10) @(posedge sys_clk);
    chk(irq, 1'b0);
    droop <= 4'hc;
    repeat (10) @(posedge sys_clk);
    chk(irq, 1'b1);
    rd(OFF_IRQ_STATUS, 8'h0c);
    wr(OFF_IRQ_STATUS, 8'h0c);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 8'h00);
    wr(OFF_LINEAR_CTRL, {lsel_w, 4'h1});
    chk({lb_sel, la_sel}, lsel_w);
    repeat (6) @(posedge sys_clk);
    rd(OFF_REG_STATUS, {~usb_low, ~ac_low, 6'h0b});
    chk(lb_en, 1'b0);
    wr(OFF_LINEAR_CTRL, 8'h00);
    chk(la_en, 1'b0);
    wr(OFF_LINEAR_CTRL, RST_LINEAR_CTRL);
    droop <= 4'h0;
    ot <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(pf_n, 1'b1);
    ot <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      seq <= ~seq;
      wr(OFF_CONV_CTRL_A, io_ctl | (k == 1 ? 8'h80 : 8'h00));
      chk(forced_pwm_bit, k == 1);
      io_ap <= (k == 2) && seq;
      core_ap <= (k == 2) && !seq;
      repeat (4) @(posedge sys_clk);
      if (k == 0)
        vcc_low <= 1'b1;
      else
        ot <= 1'b1;
      till(2);
      chk({io_en, core_en}, 2'b11);
      till(1);
      order();
      till(4);
      repeat (4) @(posedge sys_clk);
      chk(por_n, 1'b0);
      rd(OFF_REG_STATUS, {~usb_low, ~ac_low, k != 0, k == 0, 4'hf});
      vcc_low <= 1'b0;
      ot <= 1'b0;
      till(0);
      order();
      till(3);
    end
    finish_test();
  end
endmodule // rail_supervisor_sequencer_test
`default_nettype wire
